// ==== common/ddc_pkg.sv ====
package ddc_pkg;
	// ==========================================================
	// widths
	localparam int ADDR_W = 20;
	localparam int BANK_W = 4;
	localparam int NBANK = 16;
	localparam int DATA_W = 18;
	localparam int NMODE = 3;

	// ==========================================================
	// command pair {write strobe, refresh strobe} with select low
	localparam logic [1:0] CMD_MODE_SET = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_REFRESH = 2'h2;
	localparam logic [1:0] CMD_READ = 2'h3;

	// ==========================================================
	// mode register fields and reset value
	localparam logic [ADDR_W-1:0] MODE_RESET = 20'h00000;
	localparam int ROW_CYC_LO = 0;
	localparam int BURST_LEN_LO = 8;
	localparam int WMODE_LO = 3;
	localparam int REFMULTI_BIT = 5;
	localparam logic [1:0] WMODE_DUAL = 2'h1;
	localparam logic [1:0] WMODE_QUAD = 2'h2;
	localparam logic [1:0] BL_FOUR = 2'h1;
	localparam logic [1:0] BL_EIGHT = 2'h2;
	// data organisation is fixed at build: 0 narrow word, 1 wide word
	localparam logic ORG_WIDE = 1'b0;

	// ==========================================================
	// timing
	localparam int CLK_MHZ = 100;
	localparam int MSR_NS = 120;
	localparam int MSR_CYC = (MSR_NS * CLK_MHZ + 999) / 1000;
	localparam int BURST_MAX_CYC = 4;

	// ==========================================================
	// controller register offsets
	localparam logic [7:0] REG_ADDR = 8'h00;
	localparam logic [7:0] REG_BANK = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	localparam logic [7:0] REG_WDATA = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int WDATA_MASK_BIT = 18;

	// ==========================================================
	// device states
	typedef enum logic [2:0]
	{
		DS_IDLE = 3'h1,
		DS_RECOVER = 3'h2,
		DS_BURST = 3'h4
	} ddc_dev_state_t;

	// banks touched by a write or refresh; read touches one bank
	function automatic logic [NBANK-1:0] ddc_target_banks(
		input logic [1:0] kind,
		input logic [BANK_W-1:0] bank,
		input logic [ADDR_W-1:0] addr,
		input logic [1:0] wmode,
		input logic refmulti);
		logic [NBANK-1:0] sel;
		sel = '0;
		for (int i = 0; i < NBANK; i++)
		begin
			if (kind == CMD_WRITE && wmode == WMODE_DUAL)
				sel[i] = (i[2:0] == bank[2:0]);
			else if (kind == CMD_WRITE && wmode == WMODE_QUAD)
				sel[i] = (i[1:0] == bank[1:0]);
			else
				sel[i] = (i[3:0] == bank);
		end
		if (kind == CMD_REFRESH && refmulti)
			sel = addr[NBANK-1:0];
		return sel;
	endfunction
endpackage

// ==== common/ddc_link_if.sv ====
interface ddc_link_if;
	logic cs_n; // chip select, low selects
	logic we_n; // write strobe
	logic ref_n; // refresh strobe
	logic [ddc_pkg::ADDR_W-1:0] addr; // address or opcode
	logic [ddc_pkg::BANK_W-1:0] bank; // bank select
	logic wvalid; // write data beat present
	logic [ddc_pkg::DATA_W-1:0] wdata; // write data beat
	logic byte_mask; // high drops the beat

	modport dev (input cs_n, input we_n, input ref_n, input addr, input bank,
		input wvalid, input wdata, input byte_mask);
	modport ctl (output cs_n, output we_n, output ref_n, output addr, output bank,
		output wvalid, output wdata, output byte_mask);
endinterface

// ==== src/ddc_dev_end.sv ====
// Function
// - select high: no new command, work continues
// - strobe pair decodes mode set, read, write, refresh
// - mode set stores address into mode register
// - low two bank bits pick mode register
// - mode registers hold until rewritten or reset
// - controller sets mode only with banks idle
// - controller waits recovery after mode set
// - read uses four bank, twenty address bits
// - write mode field picks single/dual/quad bank
// - write bank bits top index 3/2/1
// - beat stored only when byte mask low
// - refresh by bank or multibank up to four; here any mask of the 16 banks in addr is taken
// - refresh uses bank or address per method
// - controller issues every refresh separately
// - used address bits follow burst and organisation
// - inputs sampled on rising clock edge
// - controller keeps row cycle per bank
//
// The address map and the strobed register port were chosen for this implementation.
module ddc_dev_end (
	input wire logic mclk, // device clock
	input wire logic rst_n, // async reset, low active
	ddc_link_if.dev link, // command link from controller
	output logic [ddc_pkg::ADDR_W-1:0] mode_reg_zero, // mode register 0
	output logic [ddc_pkg::ADDR_W-1:0] mode_reg_one, // mode register 1
	output logic [ddc_pkg::ADDR_W-1:0] mode_reg_two, // mode register 2
	output logic rd_go, // read burst start pulse
	output logic wr_go, // write burst start pulse
	output logic ref_go, // refresh pulse
	output logic [ddc_pkg::BANK_W-1:0] acc_bank, // bank of read or write
	output logic [ddc_pkg::ADDR_W-1:0] acc_addr, // location, unused bits zero
	output logic [ddc_pkg::NBANK-1:0] bank_sel, // banks touched
	output logic store_en, // beat written pulse
	output logic [ddc_pkg::DATA_W-1:0] store_data, // beat written
	output logic recovering, // mode set recovery under way
	output logic mode_set_reject // mode set dropped in burst
);
	// ==========================================================
	// decode
	logic [ddc_pkg::ADDR_W-1:0] mr_reg [ddc_pkg::NMODE];
	ddc_pkg::ddc_dev_state_t state_reg;
	ddc_pkg::ddc_dev_state_t state_next;
	logic [7:0] rec_cnt_reg;
	logic [7:0] rec_cnt_next;
	logic [2:0] burst_cnt_reg;
	logic [2:0] burst_cnt_next;
	logic take;
	logic [1:0] pair;
	logic do_mode;
	logic do_rw;
	logic do_ref;
	logic [2:0] beats;
	logic [1:0] drop;
	logic [ddc_pkg::ADDR_W-1:0] addr_mask;
	logic [1:0] bl_field;
	logic [1:0] wmode;
	logic refmulti;

	// select high or recovery means nothing is taken; bursts keep counting
	assign take = !link.cs_n && state_reg != ddc_pkg::DS_RECOVER;
	assign pair = {link.we_n, link.ref_n};
	assign do_mode = take && pair == ddc_pkg::CMD_MODE_SET && state_reg == ddc_pkg::DS_IDLE;
	assign do_rw = take && (pair == ddc_pkg::CMD_READ || pair == ddc_pkg::CMD_WRITE);
	assign do_ref = take && pair == ddc_pkg::CMD_REFRESH;

	// fields live in the stored mode words
	assign bl_field = mr_reg[1][ddc_pkg::BURST_LEN_LO +: 2];
	assign wmode = mr_reg[2][ddc_pkg::WMODE_LO +: 2];
	assign refmulti = mr_reg[2][ddc_pkg::REFMULTI_BIT];

	// longer bursts and the wide word need fewer address bits
	always_comb
	begin
		drop = 2'h0;
		beats = 3'h1;
		if (bl_field == ddc_pkg::BL_FOUR)
		begin
			drop = 2'h1;
			beats = 3'h2;
		end
		else if (bl_field == ddc_pkg::BL_EIGHT)
		begin
			drop = 2'h2;
			beats = 3'h4;
		end
		drop = drop + {1'b0, ddc_pkg::ORG_WIDE};
		addr_mask = {ddc_pkg::ADDR_W{1'b1}} >> drop;
	end

	// ==========================================================
	// mode registers
	// only a mode set in idle writes; reset alone clears them
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < ddc_pkg::NMODE; i++)
				mr_reg[i] <= ddc_pkg::MODE_RESET;
		end
		else if (do_mode && link.bank[1:0] != 2'h3)
			mr_reg[link.bank[1:0]] <= link.addr;
	end

	assign mode_reg_zero = mr_reg[0];
	assign mode_reg_one = mr_reg[1];
	assign mode_reg_two = mr_reg[2];

	// ==========================================================
	// state machine
	always_comb
	begin
		state_next = state_reg;
		rec_cnt_next = rec_cnt_reg;
		burst_cnt_next = burst_cnt_reg;
		case (state_reg)
			ddc_pkg::DS_IDLE:
			begin
				if (do_mode)
				begin
					state_next = ddc_pkg::DS_RECOVER;
					rec_cnt_next = 8'(ddc_pkg::MSR_CYC - 1);
				end
				else if (do_rw)
				begin
					state_next = ddc_pkg::DS_BURST;
					burst_cnt_next = beats - 3'h1;
				end
			end
			ddc_pkg::DS_RECOVER:
			begin
				if (rec_cnt_reg == 8'h00)
					state_next = ddc_pkg::DS_IDLE;
				else
					rec_cnt_next = rec_cnt_reg - 8'h01;
			end
			ddc_pkg::DS_BURST:
			begin
				// a new read or write restarts the burst window
				if (do_rw)
					burst_cnt_next = beats - 3'h1;
				else if (burst_cnt_reg == 3'h0)
					state_next = ddc_pkg::DS_IDLE;
				else
					burst_cnt_next = burst_cnt_reg - 3'h1;
			end
			default:
				state_next = ddc_pkg::DS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ddc_pkg::DS_IDLE;
			rec_cnt_reg <= 8'h00;
			burst_cnt_reg <= 3'h0;
		end
		else
		begin
			state_reg <= state_next;
			rec_cnt_reg <= rec_cnt_next;
			burst_cnt_reg <= burst_cnt_next;
		end
	end

	// ==========================================================
	// command outputs
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_go <= 1'b0;
			wr_go <= 1'b0;
			ref_go <= 1'b0;
			acc_bank <= '0;
			acc_addr <= '0;
			bank_sel <= '0;
			mode_set_reject <= 1'b0;
			recovering <= 1'b0;
		end
		else
		begin
			rd_go <= do_rw && pair == ddc_pkg::CMD_READ;
			wr_go <= do_rw && pair == ddc_pkg::CMD_WRITE;
			ref_go <= do_ref;
			// mode set during a burst is a controller fault; flag, do not obey
			mode_set_reject <= take && pair == ddc_pkg::CMD_MODE_SET &&
				state_reg == ddc_pkg::DS_BURST;
			recovering <= state_next == ddc_pkg::DS_RECOVER;
			if (do_rw)
			begin
				acc_bank <= link.bank;
				acc_addr <= link.addr & addr_mask;
			end
			// bank set only, address ignored unless multibank refresh
			if (do_rw || do_ref)
				bank_sel <= ddc_pkg::ddc_target_banks(pair, link.bank, link.addr,
					wmode, refmulti);
		end
	end

	// ==========================================================
	// write beats
	// the mask is taken on the same edge as its beat
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			store_en <= 1'b0;
			store_data <= '0;
		end
		else
		begin
			store_en <= link.wvalid && !link.byte_mask;
			if (link.wvalid && !link.byte_mask)
				store_data <= link.wdata;
		end
	end
endmodule

// ==== src/ddc_ctl_end.sv ====
module ddc_ctl_end (
	input wire logic mclk, // clock
	input wire logic rst_n, // async reset, low active
	ddc_link_if.ctl link, // command link to device
	input wire logic [7:0] host_addr, // register byte address
	input wire logic [31:0] host_wdata, // write data
	input wire logic host_wr, // write strobe
	input wire logic host_rd, // read strobe
	output logic [31:0] host_rdata // read data, cycle after strobe
);
	// ==========================================================
	// host registers
	logic [ddc_pkg::ADDR_W-1:0] addr_reg;
	logic [ddc_pkg::BANK_W-1:0] bank_reg;
	logic [1:0] kind_reg;
	logic pend_reg;
	logic [3:0] rowc_reg;
	logic [1:0] wmode_reg;
	logic refmulti_reg;
	logic [7:0] rec_cnt_reg;
	logic [2:0] burst_cnt_reg;
	logic [3:0] rc_cnt_reg [ddc_pkg::NBANK];
	logic [ddc_pkg::NBANK-1:0] busy_banks;
	logic [ddc_pkg::NBANK-1:0] tgt;
	logic go;

	// banks still inside their row cycle
	always_comb
	begin
		for (int i = 0; i < ddc_pkg::NBANK; i++)
			busy_banks[i] = rc_cnt_reg[i] != 4'h0;
	end

	assign tgt = ddc_pkg::ddc_target_banks(kind_reg, bank_reg, addr_reg,
		wmode_reg, refmulti_reg);

	// mode set waits for all banks idle and no burst; others for their banks
	always_comb
	begin
		go = pend_reg && rec_cnt_reg == 8'h00;
		if (kind_reg == ddc_pkg::CMD_MODE_SET)
			go = go && busy_banks == '0 && burst_cnt_reg == 3'h0;
		else
			go = go && (busy_banks & tgt) == '0;
	end

	// a command write is ignored while one is pending
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			addr_reg <= '0;
			bank_reg <= '0;
			kind_reg <= ddc_pkg::CMD_READ;
			pend_reg <= 1'b0;
		end
		else
		begin
			if (host_wr && host_addr == ddc_pkg::REG_ADDR)
				addr_reg <= host_wdata[ddc_pkg::ADDR_W-1:0];
			if (host_wr && host_addr == ddc_pkg::REG_BANK)
				bank_reg <= host_wdata[ddc_pkg::BANK_W-1:0];
			if (host_wr && host_addr == ddc_pkg::REG_CMD && !pend_reg)
			begin
				kind_reg <= host_wdata[1:0];
				pend_reg <= 1'b1;
			end
			else if (go)
				pend_reg <= 1'b0;
		end
	end

	// ==========================================================
	// timing guards
	// recovery count is one longer: device counts from its sampling edge
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rec_cnt_reg <= 8'h00;
			burst_cnt_reg <= 3'h0;
			rowc_reg <= 4'h0;
			wmode_reg <= 2'h0;
			refmulti_reg <= 1'b0;
			for (int i = 0; i < ddc_pkg::NBANK; i++)
				rc_cnt_reg[i] <= 4'h0;
		end
		else
		begin
			if (go && kind_reg == ddc_pkg::CMD_MODE_SET)
				rec_cnt_reg <= 8'(ddc_pkg::MSR_CYC + 1);
			else if (rec_cnt_reg != 8'h00)
				rec_cnt_reg <= rec_cnt_reg - 8'h01;
			if (go && (kind_reg == ddc_pkg::CMD_READ || kind_reg == ddc_pkg::CMD_WRITE))
				burst_cnt_reg <= 3'(ddc_pkg::BURST_MAX_CYC + 1);
			else if (burst_cnt_reg != 3'h0)
				burst_cnt_reg <= burst_cnt_reg - 3'h1;
			// shadow the fields the guards depend on
			if (go && kind_reg == ddc_pkg::CMD_MODE_SET && bank_reg[1:0] == 2'h0)
				rowc_reg <= addr_reg[ddc_pkg::ROW_CYC_LO +: 4];
			if (go && kind_reg == ddc_pkg::CMD_MODE_SET && bank_reg[1:0] == 2'h2)
			begin
				wmode_reg <= addr_reg[ddc_pkg::WMODE_LO +: 2];
				refmulti_reg <= addr_reg[ddc_pkg::REFMULTI_BIT];
			end
			// zero programmed row cycle still spaces by one clock
			for (int i = 0; i < ddc_pkg::NBANK; i++)
			begin
				if (go && kind_reg != ddc_pkg::CMD_MODE_SET && tgt[i])
					rc_cnt_reg[i] <= (rowc_reg == 4'h0) ? 4'h1 : rowc_reg;
				else if (rc_cnt_reg[i] != 4'h0)
					rc_cnt_reg[i] <= rc_cnt_reg[i] - 4'h1;
			end
		end
	end

	// ==========================================================
	// link drive
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link.cs_n <= 1'b1;
			link.we_n <= 1'b1;
			link.ref_n <= 1'b1;
			link.addr <= '0;
			link.bank <= '0;
			link.wvalid <= 1'b0;
			link.wdata <= '0;
			link.byte_mask <= 1'b0;
		end
		else
		begin
			link.cs_n <= !go;
			link.we_n <= go ? kind_reg[1] : 1'b1;
			link.ref_n <= go ? kind_reg[0] : 1'b1;
			if (go)
			begin
				link.addr <= addr_reg;
				link.bank <= bank_reg;
			end
			link.wvalid <= host_wr && host_addr == ddc_pkg::REG_WDATA;
			if (host_wr && host_addr == ddc_pkg::REG_WDATA)
			begin
				link.wdata <= host_wdata[ddc_pkg::DATA_W-1:0];
				link.byte_mask <= host_wdata[ddc_pkg::WDATA_MASK_BIT];
			end
		end
	end

	// ==========================================================
	// read back
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			host_rdata <= 32'h00000000;
		else if (host_rd)
		begin
			case (host_addr)
				ddc_pkg::REG_ADDR: host_rdata <= {12'h000, addr_reg};
				ddc_pkg::REG_BANK: host_rdata <= {28'h0000000, bank_reg};
				ddc_pkg::REG_CMD: host_rdata <= {30'h00000000, kind_reg};
				ddc_pkg::REG_STATUS: host_rdata <= {13'h0000, busy_banks,
					burst_cnt_reg != 3'h0, rec_cnt_reg != 8'h00, pend_reg};
				default: host_rdata <= 32'h00000000;
			endcase
		end
		else
			host_rdata <= 32'h00000000;
	end
endmodule

// ==== verif/ddc_link_chk_sva.sv ====
module ddc_link_chk (
	input wire logic mclk, // clock
	input wire logic rst_n, // async reset, low active
	input wire logic cs_n, // chip select
	input wire logic we_n, // write strobe
	input wire logic ref_n, // refresh strobe
	input wire logic [ddc_pkg::ADDR_W-1:0] addr, // address
	input wire logic [ddc_pkg::BANK_W-1:0] bank, // bank select
	input wire logic wvalid, // beat present
	input wire logic [ddc_pkg::DATA_W-1:0] wdata, // beat
	input wire logic byte_mask, // drop beat
	input wire logic rd_go, // read pulse
	input wire logic wr_go, // write pulse
	input wire logic ref_go, // refresh pulse
	input wire logic [ddc_pkg::BANK_W-1:0] acc_bank, // access bank
	input wire logic [ddc_pkg::NBANK-1:0] bank_sel, // banks touched
	input wire logic store_en, // beat stored
	input wire logic [ddc_pkg::DATA_W-1:0] store_data, // stored beat
	input wire logic recovering, // recovery under way
	input wire logic [ddc_pkg::ADDR_W-1:0] mode_reg_zero, // mode register 0
	input wire logic [ddc_pkg::ADDR_W-1:0] mode_reg_two // mode register 2
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// a command the device must take at this edge
	sequence s_take(logic [1:0] k);
		!cs_n && !recovering && {we_n, ref_n} == k;
	endsequence
	// recovery spans twelve edges, split to keep repetitions short
	sequence s_rec_span;
		recovering [*8] ##1 recovering [*4] ##1 !recovering;
	endsequence

	chk_read_start: assert property (s_take(ddc_pkg::CMD_READ) |=> rd_go && acc_bank == $past(bank))
		else $error("read not started on its bank");
	chk_write_start: assert property (s_take(ddc_pkg::CMD_WRITE) |=> wr_go && !rd_go)
		else $error("write not started");
	chk_refresh_start: assert property (s_take(ddc_pkg::CMD_REFRESH) |=> ref_go && !wr_go)
		else $error("refresh not started");
	chk_deselect_idle: assert property (cs_n |=> !(rd_go || wr_go || ref_go))
		else $error("command taken while deselected");
	chk_mode_store: assert property (s_take(ddc_pkg::CMD_MODE_SET) ##0 bank[1:0] == 2'h2 |=> mode_reg_two == $past(addr))
		else $error("mode register two not loaded");
	chk_mode_hold: assert property (!(!cs_n && {we_n, ref_n} == ddc_pkg::CMD_MODE_SET) |=> $stable(mode_reg_two) && $stable(mode_reg_zero))
		else $error("mode register changed without mode set");
	chk_recover_span: assert property (s_take(ddc_pkg::CMD_MODE_SET) |=> s_rec_span)
		else $error("recovery length wrong");
	chk_recover_block: assert property (recovering && !cs_n |=> !(rd_go || wr_go || ref_go))
		else $error("command taken during recovery");
	// a burst spans at most four edges from its start pulse; no mode set inside it
	chk_mode_idle: assert property ((rd_go || wr_go) |-> (!(!cs_n && {we_n, ref_n} == ddc_pkg::CMD_MODE_SET)) [*4])
		else $error("mode set issued inside a burst");
	chk_beat_mask: assert property (wvalid |=> store_en == !$past(byte_mask))
		else $error("beat store ignores mask");
	chk_beat_data: assert property (wvalid && !byte_mask |=> store_data == $past(wdata))
		else $error("stored beat differs");
	chk_refresh_banks: assert property (s_take(ddc_pkg::CMD_REFRESH) |=> bank_sel == (mode_reg_two[ddc_pkg::REFMULTI_BIT] ? $past(addr[15:0]) : 16'h0001 << $past(bank)))
		else $error("refresh bank set wrong");
endmodule

// ==== verif/dram_command_decoder_tb.sv ====
module dram_command_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] host_addr = 8'h00;
	logic [31:0] host_wdata = 32'h0;
	logic host_wr = 1'b0;
	logic host_rd = 1'b0;
	logic [31:0] host_rdata, st;
	logic [19:0] mz, mo, mt, acc_addr, b_mz, b_mo, b_mt, b_addr;
	logic [3:0] acc_bank, b_bank;
	logic [15:0] bank_sel, b_sel;
	logic [17:0] store_data, b_data;
	logic rd_go, wr_go, ref_go, store_en, recovering, reject;
	logic b_rd, b_wr, b_ref, b_st, b_rec, b_rej;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	int n_rd = 0, n_wr = 0, n_ref = 0, n_st = 0, b_nrd = 0, b_nrec = 0, b_nrej = 0;
	int n_rej = 0;
	ddc_link_if link();
	ddc_link_if link2();

	always #5 mclk = ~mclk;

	// ==========================================================
	// first pair: controller faces device; second device driven raw
	ddc_ctl_end ddc_ctl_end_inst (.mclk(mclk), .rst_n(rst_n), .link(link), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata));
	ddc_dev_end ddc_dev_end_inst (.mclk(mclk), .rst_n(rst_n), .link(link), .mode_reg_zero(mz),
		.mode_reg_one(mo), .mode_reg_two(mt), .rd_go(rd_go), .wr_go(wr_go), .ref_go(ref_go),
		.acc_bank(acc_bank), .acc_addr(acc_addr), .bank_sel(bank_sel), .store_en(store_en),
		.store_data(store_data), .recovering(recovering), .mode_set_reject(reject));
	ddc_dev_end ddc_dev_end_inst2 (.mclk(mclk), .rst_n(rst_n), .link(link2), .mode_reg_zero(b_mz),
		.mode_reg_one(b_mo), .mode_reg_two(b_mt), .rd_go(b_rd), .wr_go(b_wr), .ref_go(b_ref),
		.acc_bank(b_bank), .acc_addr(b_addr), .bank_sel(b_sel), .store_en(b_st),
		.store_data(b_data), .recovering(b_rec), .mode_set_reject(b_rej));
	ddc_link_chk ddc_link_chk_inst (.mclk(mclk), .rst_n(rst_n), .cs_n(link.cs_n), .we_n(link.we_n),
		.ref_n(link.ref_n), .addr(link.addr), .bank(link.bank), .wvalid(link.wvalid),
		.wdata(link.wdata), .byte_mask(link.byte_mask), .rd_go(rd_go), .wr_go(wr_go),
		.ref_go(ref_go), .acc_bank(acc_bank), .bank_sel(bank_sel), .store_en(store_en),
		.store_data(store_data), .recovering(recovering), .mode_reg_zero(mz), .mode_reg_two(mt));

	// pulse counters and hang guard; a pulse is seen at the edge after it rose
	always @(posedge mclk)
	begin
		cycles++;
		if (rd_go === 1'b1) n_rd++;
		if (wr_go === 1'b1) n_wr++;
		if (ref_go === 1'b1) n_ref++;
		if (store_en === 1'b1) n_st++;
		if (b_rd === 1'b1) b_nrd++;
		if (b_rec === 1'b1) b_nrec++;
		if (b_rej === 1'b1) b_nrej++;
		if (reject === 1'b1) n_rej++;
		if (cycles == 5000)
		begin
			bad_count++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		host_wr <= 1'b1;
		host_addr <= a;
		host_wdata <= d;
		@(posedge mclk);
		host_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		host_rd <= 1'b1;
		host_addr <= a;
		@(posedge mclk);
		host_rd <= 1'b0;
		#1 d = host_rdata;
	endtask

	// load operands, launch, then poll until pending, recovery and burst clear
	task automatic go(input logic [1:0] kind, input logic [31:0] a, input logic [31:0] b);
		wr(ddc_pkg::REG_ADDR, a);
		wr(ddc_pkg::REG_BANK, b);
		wr(ddc_pkg::REG_CMD, {30'h0, kind});
		st = 32'h1;
		for (int i = 0; i < 40 && st[2:0] !== 3'h0; i++) rd(ddc_pkg::REG_STATUS, st);
		// a poll that runs out leaves pending, recovery or burst set
		chk(st[2:0], 3'h0);
		repeat (3) @(posedge mclk);
	endtask

	// raw link driver for the second device; holds until the next call
	task automatic lk(input logic cs, input logic [1:0] k, input logic [3:0] bk, input logic [19:0] ad);
		@(posedge mclk);
		link2.cs_n <= cs;
		{link2.we_n, link2.ref_n} <= k;
		link2.bank <= bk;
		link2.addr <= ad;
	endtask

	// banks a write to bank 13 should touch for each write mode
	function automatic logic [15:0] exp_wr(input int wm);
		logic [15:0] s;
		logic [3:0] m;
		m = (wm == 1) ? 4'h7 : (wm == 2) ? 4'h3 : 4'hf;
		for (int i = 0; i < 16; i++) s[i] = ((4'(i) ^ 4'hd) & m) == 4'h0;
		return s;
	endfunction

	task automatic summarize();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		link2.cs_n = 1'b1;
		link2.we_n = 1'b1;
		link2.ref_n = 1'b1;
		link2.addr = 20'h00000;
		link2.bank = 4'h0;
		link2.wvalid = 1'b0;
		link2.wdata = 18'h00000;
		link2.byte_mask = 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk(mz, 20'h00000);
		chk(link.cs_n, 1'b1);
		go(ddc_pkg::CMD_MODE_SET, 32'h00002, 32'h0);
		// host registers read back the operands of the last command
		rd(ddc_pkg::REG_ADDR, st);
		chk(st, 32'h00000002);
		rd(ddc_pkg::REG_CMD, st);
		chk(st, 32'h00000000);
		go(ddc_pkg::CMD_MODE_SET, 32'h00100, 32'h1);
		chk(mz, 20'h00002);
		chk(mo, 20'h00100);
		chk(mt, 20'h00000);
		go(ddc_pkg::CMD_READ, 32'hfffff, 32'h5);
		chk(acc_bank, 4'h5);
		chk(acc_addr, 20'hfffff >> (1 + ddc_pkg::ORG_WIDE));
		chk(bank_sel, 16'h0020);
		chk(n_rd, 1);
		for (int wm = 0; wm < 3; wm++)
		begin
			go(ddc_pkg::CMD_MODE_SET, 32'(wm << 3), 32'h2);
			go(ddc_pkg::CMD_WRITE, 32'h00010, 32'hd);
			chk(mt, 20'(wm << 3));
			chk(bank_sel, exp_wr(wm));
		end
		chk(n_wr, 3);
		// unmasked beat then masked beat, one idle cycle apart
		wr(ddc_pkg::REG_WDATA, {13'h0, 1'b0, 18'h2aaaa});
		wr(ddc_pkg::REG_WDATA, {13'h0, 1'b1, 18'h15555});
		repeat (3) @(posedge mclk);
		chk(n_st, 1);
		chk(store_data, 18'h2aaaa);
		go(ddc_pkg::CMD_MODE_SET, 32'h0, 32'h2);
		go(ddc_pkg::CMD_REFRESH, 32'h50011, 32'h7);
		chk(bank_sel, 16'h0080);
		// same refresh again: bank 7 busy two edges, then free
		wr(ddc_pkg::REG_CMD, {30'h0, ddc_pkg::CMD_REFRESH});
		rd(ddc_pkg::REG_STATUS, st);
		chk(st[18:3], 16'h0080);
		rd(ddc_pkg::REG_STATUS, st);
		chk(st[18:3], 16'h0000);
		go(ddc_pkg::CMD_MODE_SET, 32'h00020, 32'h2);
		go(ddc_pkg::CMD_REFRESH, 32'h50011, 32'h7);
		chk(bank_sel, 16'h0011);
		chk(n_ref, 3);
		chk(mz, 20'h00002);
		// second device: deselect, recovery window, mode set inside a burst
		lk(1'b1, ddc_pkg::CMD_READ, 4'h3, 20'h0);
		lk(0, ddc_pkg::CMD_MODE_SET, 4'h1, 20'h00abc);
		lk(0, ddc_pkg::CMD_READ, 4'h3, 20'h1);
		lk(1'b1, ddc_pkg::CMD_READ, 4'h3, 20'h0);
		repeat (14) @(posedge mclk);
		chk(b_nrd, 0);
		chk(b_mo, 20'h00abc);
		chk(b_nrec, ddc_pkg::MSR_CYC);
		lk(0, ddc_pkg::CMD_READ, 4'h3, 20'h1);
		lk(0, ddc_pkg::CMD_MODE_SET, 4'h0, 20'h00fff);
		lk(1'b1, ddc_pkg::CMD_READ, 4'h3, 20'h0);
		repeat (3) @(posedge mclk);
		chk(b_nrd, 1);
		chk(b_bank, 4'h3);
		chk(b_sel, 16'h0008);
		chk(b_addr, 20'h00001);
		chk(b_nrej, 1);
		chk(b_mz, 20'h00000);
		chk(b_nrec, ddc_pkg::MSR_CYC);
		// reset in mid-run clears the mode registers
		@(posedge mclk);
		rst_n <= 1'b0;
		@(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk(mt, 20'h00000);
		chk(n_rej, 0);
		summarize();
	end
endmodule
